// File: core/watch_timer_pkg.sv
// constants, field layout and decode helpers of the watch interval timer
// assumes a 250 MHz system clock and a 32.768 kHz watch clock
//
// How it works
// R1: bit 7 picks clk/128 or subsystem clock
// R2: request forwarded only while bit 6 set
// R3: buzzer field picks 0.5/1/2/4 kHz tone
// R4: speed field picks 1 s, 0.5 s, 0.25 s, 3.91 ms
// R5: enable low stops and clears divider chain
// R6: pending bit 0 cleared by writing zero
// R7: figures assume 32.768 kHz, scale otherwise
// R8: software uses direct register access only
// R9: elapsed interval sets pending, raises request
package watch_timer_pkg;

    // clock figures
    localparam int CLK_HZ       = 250_000_000; // system clock rate
    localparam int PRE_DIV      = 128;          // main clock prescale
    localparam int FW_HZ        = 32768;        // nominal watch clock

    // interval times in their own units
    localparam int INT_HALF_MS  = 500;          // speed 01
    localparam int INT_QUART_MS = 250;          // speed 10
    localparam int INT_FAST_US  = 3910;         // speed 11
    localparam int INT_SLOW_MS  = 1000;         // speed 00

    // interval lengths in watch clock ticks, rounded down
    localparam int INT_HALF_TICKS  = INT_HALF_MS * FW_HZ / 1000;
    localparam int INT_QUART_TICKS = INT_QUART_MS * FW_HZ / 1000;
    localparam int INT_FAST_TICKS  = INT_FAST_US * FW_HZ / 1000000;
    localparam int INT_SLOW_TICKS  = INT_SLOW_MS * FW_HZ / 1000;

    // masks of divider bits that wrap at each interval
    localparam logic [14:0] MASK_HALF  = 15'(INT_HALF_TICKS - 1);
    localparam logic [14:0] MASK_QUART = 15'(INT_QUART_TICKS - 1);
    localparam logic [14:0] MASK_FAST  = 15'(INT_FAST_TICKS - 1);
    localparam logic [14:0] MASK_SLOW  = 15'(INT_SLOW_TICKS - 1);

    // buzzer tones in hz and the divider bit that gives each
    localparam int TONE_0_HZ = 500;
    localparam int TONE_1_HZ = 1000;
    localparam int TONE_2_HZ = 2000;
    localparam int TONE_3_HZ = 4000;
    localparam logic [3:0] BUZ_BIT_0 = 4'($clog2(FW_HZ / (2 * TONE_0_HZ)));
    localparam logic [3:0] BUZ_BIT_1 = 4'($clog2(FW_HZ / (2 * TONE_1_HZ)));
    localparam logic [3:0] BUZ_BIT_2 = 4'($clog2(FW_HZ / (2 * TONE_2_HZ)));
    localparam logic [3:0] BUZ_BIT_3 = 4'($clog2(FW_HZ / (2 * TONE_3_HZ)));

    // register indices; byte address is four times the index
    localparam logic [9:0] CTRL_IDX   = 10'h0d1; // watch_ctrl_reg
    localparam logic [9:0] STAT_IDX   = 10'h0d2; // sticky event status
    localparam logic [9:0] CLR_IDX    = 10'h0d3; // write one to clear
    localparam logic [9:0] IRQEN_IDX  = 10'h0d4; // status enable

    // control field positions
    localparam int SEL_BIT  = 7; // clock select
    localparam int IE_BIT   = 6; // interrupt enable
    localparam int BUZ_LSB  = 4; // buzzer field, 2 bits
    localparam int SPD_LSB  = 2; // speed field, 2 bits
    localparam int EN_BIT   = 1; // timer enable
    localparam int PEND_BIT = 0; // pending flag

    // reset value and prescaler end count
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [6:0] PRE_MAX  = 7'(PRE_DIV - 1);

    // byte address match for one register index
    function automatic logic reg_hit(input logic [11:0] addr,
                                     input logic [9:0]  idx);
        reg_hit = (addr == {idx, 2'b00});
    endfunction : reg_hit

    // divider bits that must all be set at the end of an interval
    function automatic logic [14:0] interval_mask(input logic [1:0] spd);
        unique case (spd)
            2'b00: interval_mask = MASK_SLOW;
            2'b01: interval_mask = MASK_HALF;
            2'b10: interval_mask = MASK_QUART;
            2'b11: interval_mask = MASK_FAST;
        endcase
    endfunction : interval_mask

    // divider bit that carries the selected tone
    function automatic logic [3:0] buzzer_bit(input logic [1:0] buz);
        unique case (buz)
            2'b00: buzzer_bit = BUZ_BIT_0;
            2'b01: buzzer_bit = BUZ_BIT_1;
            2'b10: buzzer_bit = BUZ_BIT_2;
            2'b11: buzzer_bit = BUZ_BIT_3;
        endcase
    endfunction : buzzer_bit

endpackage : watch_timer_pkg

// File: core/wt_div_if.sv
// bundle between the timer core and its frequency divider chain
// assumes both ends sit in the same clock domain
`timescale 1ns/10ps
`default_nettype none
interface wt_div_if;
    logic        tick;  // one watch clock period elapsed
    logic        clear; // hold chain at zero
    logic [14:0] count; // divider chain state

    modport ctrl  (output tick, output clear, input count);
    modport chain (input tick, input clear, output count);
endinterface : wt_div_if
`default_nettype wire

// File: core/watch_tick_divider.sv
// frequency divider chain counting watch clock ticks
// assumes tick is a one-cycle pulse in the clk_i domain
`timescale 1ns/10ps
`default_nettype none
module watch_tick_divider (
    input  wire logic clk_i,
    input  wire logic rst_b_i,
    wt_div_if.chain   bus
);

    logic [14:0] count_r; // ripple of binary stages

    // clear dominates so a disabled timer never advances
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            count_r <= 15'h0000;
        end else if (bus.clear) begin
            count_r <= 15'h0000; // [R5]
        end else if (bus.tick) begin
            count_r <= count_r + 15'h0001;
        end
    end

    assign bus.count = count_r;

endmodule : watch_tick_divider
`default_nettype wire

// File: core/watch_interval_timer.sv
// watch interval timer: control register, clock select, divider,
// interval events, buzzer tone and interrupt logic
// assumes an avalon-mm master on the register side and subclk_i
// synchronous to clk_i and far slower than it
`timescale 1ns/10ps
`default_nettype none
module watch_interval_timer
    import watch_timer_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        rst_b_i,
    input  wire logic [11:0] address_i,
    input  wire logic        read_i,
    input  wire logic        write_i,
    input  wire logic [31:0] writedata_i,
    input  wire logic [3:0]  byteenable_i,
    output logic      [31:0] readdata_o,
    output logic             waitrequest_o,
    input  wire logic        subclk_i,
    output logic             buzzer_o,
    output logic             wt_req_o,
    output logic             irq_o
);

    // control fields above the pending bit
    logic [7:1]  ctrl_r;      // select, ie, buzzer, speed, enable
    logic        pend_r;      // pending flag
    logic [6:0]  pre_r;       // main clock prescaler
    logic        sub_d_r;     // previous subsystem clock level
    logic        stat_r;      // sticky interval status
    logic        irq_en_r;    // status enable
    logic        waitreq_r;   // bus wait state
    logic [31:0] rdata_r;     // read data holding
    logic        buzzer_r;    // tone output
    logic        wt_req_r;    // forwarded request
    logic        irq_r;       // interrupt line

    // combinational helpers
    logic        timer_en;    // enable bit
    logic        sub_rise;    // rising edge of subsystem clock
    logic        pre_wrap;    // prescaler end of count
    logic        fw_tick;     // one watch clock period
    logic [14:0] cur_mask;    // selected interval mask
    logic        evt;         // interval elapsed
    logic        acc_take;    // request sampled this edge
    logic        wr_do;       // write completes this edge
    logic        ctrl_wr;     // write to watch_ctrl_reg
    logic        clr_wr;      // write to clear register
    logic        en_wr;       // write to enable register
    logic [31:0] rdata_nxt;   // read mux

    wt_div_if div_bus ();     // divider chain bundle

    // divider chain
    watch_tick_divider watch_tick_divider_i (
        .clk_i   (clk_i),
        .rst_b_i (rst_b_i),
        .bus     (div_bus.chain)
    );

    assign timer_en = ctrl_r[EN_BIT];

    // clock source select feeds the chain
    assign sub_rise = subclk_i && !sub_d_r;
    assign pre_wrap = (pre_r == PRE_MAX);
    assign fw_tick  = timer_en &&
                      (ctrl_r[SEL_BIT] ? sub_rise : pre_wrap); // [R1]

    assign div_bus.tick  = fw_tick;
    assign div_bus.clear = !timer_en; // [R5]

    // interval end: all masked divider bits set on a tick
    assign cur_mask = interval_mask(ctrl_r[SPD_LSB+1:SPD_LSB]);
    assign evt      = fw_tick &&
                      ((div_bus.count & cur_mask) == cur_mask); // [R4] [R7]

    // bus decode; a write lands at the edge where waitrequest is low
    assign acc_take = (read_i || write_i) && waitreq_r;
    assign wr_do    = write_i && !waitreq_r && byteenable_i[0];
    assign ctrl_wr  = wr_do && reg_hit(address_i, CTRL_IDX);
    assign clr_wr   = wr_do && reg_hit(address_i, CLR_IDX);
    assign en_wr    = wr_do && reg_hit(address_i, IRQEN_IDX);

    // subsystem clock edge history
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            sub_d_r <= 1'b0;
        end else begin
            sub_d_r <= subclk_i;
        end
    end

    // main clock divide by 128, held at zero while disabled
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            pre_r <= 7'h00;
        end else if (!timer_en) begin
            pre_r <= 7'h00; // [R5]
        end else begin
            pre_r <= pre_r + 7'h01; // [R1]
        end
    end

    // control fields, plain read/write
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            ctrl_r <= CTRL_RST[7:1];
        end else if (ctrl_wr) begin
            ctrl_r <= writedata_i[7:1];
        end
    end

    // pending flag: event set wins over a zero write
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            pend_r <= CTRL_RST[PEND_BIT];
        end else if (evt) begin
            pend_r <= 1'b1; // [R9]
        end else if (ctrl_wr && !writedata_i[PEND_BIT]) begin
            pend_r <= 1'b0; // [R6]
        end
    end

    // sticky status: event set wins over a clear
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            stat_r <= 1'b0;
        end else if (evt) begin
            stat_r <= 1'b1;
        end else if (clr_wr && writedata_i[0]) begin
            stat_r <= 1'b0;
        end
    end

    // status enable register
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            irq_en_r <= 1'b0;
        end else if (en_wr) begin
            irq_en_r <= writedata_i[0];
        end
    end

    // buzzer square wave from the selected divider stage
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            buzzer_r <= 1'b0;
        end else begin
            buzzer_r <= timer_en &&
                div_bus.count[buzzer_bit(ctrl_r[BUZ_LSB+1:BUZ_LSB])]; // [R3]
        end
    end

    // request outputs
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            wt_req_r <= 1'b0;
            irq_r    <= 1'b0;
        end else begin
            wt_req_r <= pend_r && ctrl_r[IE_BIT]; // [R2] [R9]
            irq_r    <= stat_r && irq_en_r;
        end
    end

    // read mux; unmapped and write-only addresses read zero
    always_comb begin
        rdata_nxt = 32'h0000_0000;
        if (reg_hit(address_i, CTRL_IDX)) begin
            rdata_nxt[7:0] = {ctrl_r, pend_r}; // [R6]
        end else if (reg_hit(address_i, STAT_IDX)) begin
            rdata_nxt[0] = stat_r;
        end else if (reg_hit(address_i, IRQEN_IDX)) begin
            rdata_nxt[0] = irq_en_r;
        end
    end

    // one wait state for every access
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            waitreq_r <= 1'b1;
        end else if (acc_take) begin
            waitreq_r <= 1'b0;
        end else begin
            waitreq_r <= 1'b1;
        end
    end

    // read data captured when the request is first seen
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rdata_r <= 32'h0000_0000;
        end else if (acc_take && read_i) begin
            rdata_r <= rdata_nxt;
        end
    end

    assign readdata_o    = rdata_r;
    assign waitrequest_o = waitreq_r;
    assign buzzer_o      = buzzer_r;
    assign wt_req_o      = wt_req_r;
    assign irq_o         = irq_r;

    // checks, all in the clk_i domain
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rst_b_i);

    // two disabled cycles in a row
    sequence s_held_off;
        !timer_en ##1 !timer_en;
    endsequence

    // write of zero to pending with no event in that cycle
    sequence s_pend_zero;
        ctrl_wr && !writedata_i[PEND_BIT] && !evt;
    endsequence

    // bus request seen while waiting
    sequence s_bus_req;
        (read_i || write_i) && waitreq_r;
    endsequence

    a_clk_main_div: // [R1]
        assert property (fw_tick && !ctrl_r[SEL_BIT] |->
                         pre_r == PRE_MAX && timer_en)
        else $error("main clock tick not at prescale end");

    a_clk_sub_edge: // [R1]
        assert property (fw_tick && ctrl_r[SEL_BIT] |->
                         subclk_i && !sub_d_r)
        else $error("sub clock tick without rising edge");

    a_req_gated: // [R2]
        assert property (!ctrl_r[IE_BIT] |=> !wt_req_o)
        else $error("request forwarded while disabled");

    a_buzzer_tone: // [R3]
        assert property (timer_en |=> buzzer_o ==
            $past(div_bus.count[buzzer_bit(ctrl_r[BUZ_LSB+1:BUZ_LSB])]))
        else $error("buzzer not on selected divider stage");

    a_interval_end: // [R4]
        assert property (evt |-> fw_tick &&
            (div_bus.count & interval_mask(ctrl_r[SPD_LSB+1:SPD_LSB]))
            == interval_mask(ctrl_r[SPD_LSB+1:SPD_LSB]))
        else $error("interval event off boundary");

    a_disable_clears: // [R5]
        assert property (s_held_off |-> div_bus.count == 15'h0000 &&
                         pre_r == 7'h00 && !fw_tick)
        else $error("divider not held clear while disabled");

    a_pend_clears: // [R6]
        assert property (s_pend_zero |=> !pend_r)
        else $error("pending not cleared by zero write");

    a_fast_ticks: // [R7]
        assert property (evt && ctrl_r[SPD_LSB+1:SPD_LSB] == 2'b11 |->
                         div_bus.count[6:0] == 7'h7F)
        else $error("fast interval not 128 watch ticks");

    a_event_pends: // [R9]
        assert property (evt ##1 ctrl_r[IE_BIT] |-> pend_r ##1 wt_req_o)
        else $error("interval did not pend and request");

    a_bus_answer:
        assert property (s_bus_req |=> !waitrequest_o ##1 waitrequest_o)
        else $error("bus answer not one wait state");

    // flag upkeep: set by events, dropped only by software
    // a lost flag would hide an interval from the handler
    a_event_sets: // [R9]
        assert property (evt |=> pend_r && stat_r)
        else $error("interval event did not set flags");

    a_pend_holds: // [R6]
        assert property (pend_r && !(ctrl_wr && !writedata_i[PEND_BIT]) |=>
                         pend_r)
        else $error("pending dropped without a zero write");

    a_stat_holds:
        assert property (stat_r && !(clr_wr && writedata_i[0]) |=> stat_r)
        else $error("status dropped without a clear");

    // output levels, divider step and bus answers
    a_irq_level:
        assert property (irq_o == $past(stat_r && irq_en_r))
        else $error("interrupt line not status and enable");

    a_req_follows: // [R2]
        assert property (pend_r && ctrl_r[IE_BIT] |=> wt_req_o)
        else $error("pending request not forwarded");

    a_buzzer_quiet: // [R5]
        assert property (!timer_en |=> !buzzer_o)
        else $error("buzzer toggles while disabled");

    a_chain_step: // [R1]
        assert property (fw_tick |=>
                         div_bus.count == $past(div_bus.count) + 15'h0001)
        else $error("divider did not step on a watch tick");

    a_ack_after_req:
        assert property (!waitrequest_o |-> $past(read_i || write_i))
        else $error("bus answer without a request");

endmodule : watch_interval_timer
`default_nettype wire

// File: dv/watch_interval_timer_tb.sv
// self-checking bench for the watch interval timer
// assumes the avalon-mm map and field layout of the timer package
`timescale 1ns/10ps
`default_nettype none
module watch_interval_timer_tb
    import watch_timer_pkg::*;
;
    localparam logic [11:0] A_CTRL = {CTRL_IDX, 2'b00};  // control
    localparam logic [11:0] A_STAT = {STAT_IDX, 2'b00};  // sticky status
    localparam logic [11:0] A_CLR  = {CLR_IDX, 2'b00};   // status clear
    localparam logic [11:0] A_IREN = {IRQEN_IDX, 2'b00}; // irq enable
    localparam logic [11:0] A_NONE = 12'h03fc;           // unmapped

    logic        clk_i;        // system clock
    logic        rst_b_i;      // async reset, low active
    logic [11:0] address_i;    // bus address
    logic        read_i;       // bus read
    logic        write_i;      // bus write
    logic [31:0] writedata_i;  // bus write data
    logic [3:0]  byteenable_i; // bus byte enables
    logic [31:0] readdata_o;   // bus read data
    logic        waitrequest_o;// bus stall
    logic        subclk_i;     // subsystem clock
    logic        buzzer_o;     // tone output
    logic        wt_req_o;     // timer request
    logic        irq_o;        // status interrupt
    logic        sub_run;      // lets the subsystem clock toggle
    logic [31:0] rd;           // last read value
    int          n;            // measured cycles
    int          n_mismatch;   // failed compares
    int          total_checks; // compares made

    watch_interval_timer watch_interval_timer_i (
        .clk_i(clk_i), .rst_b_i(rst_b_i), .address_i(address_i),
        .read_i(read_i), .write_i(write_i), .writedata_i(writedata_i),
        .byteenable_i(byteenable_i), .readdata_o(readdata_o),
        .waitrequest_o(waitrequest_o), .subclk_i(subclk_i),
        .buzzer_o(buzzer_o), .wt_req_o(wt_req_o), .irq_o(irq_o)
    );

    // 250 mhz system clock
    initial begin
        clk_i = 1'b0;
        forever #2 clk_i = ~clk_i;
    end

    // subsystem clock, one rise every two system cycles
    always @(posedge clk_i) begin
        if (sub_run) begin
            subclk_i <= ~subclk_i;
        end
    end

    // verdict and end of run
    task automatic final_report();
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : final_report

    // compare a value, report a mismatch
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check

    // compare a measured count against a window
    task automatic near(input int got, input int exp, input int tol);
        total_checks++;
        if (got < exp - tol || got > exp + tol) begin
            n_mismatch++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : near

    // one avalon write, held until waitrequest low
    task automatic bus_write(input logic [11:0] a, input logic [31:0] d,
                             input logic [3:0] be);
        address_i    <= a;
        writedata_i  <= d;
        byteenable_i <= be;
        write_i      <= 1'b1;
        @(posedge clk_i);
        // only the watchdog ends this wait
        while (waitrequest_o !== 1'b0) begin
            @(posedge clk_i);
        end
        write_i <= 1'b0;
        @(posedge clk_i);
    endtask : bus_write

    // one avalon read, data taken at the completing edge
    task automatic bus_read(input logic [11:0] a, input logic [31:0] exp);
        address_i <= a;
        read_i    <= 1'b1;
        @(posedge clk_i);
        // only the watchdog ends this wait
        while (waitrequest_o !== 1'b0) begin
            @(posedge clk_i);
        end
        rd = readdata_o;
        read_i <= 1'b0;
        @(posedge clk_i);
        check(rd, exp);
    endtask : bus_read

    // cycles until the timer request rises, bounded
    task automatic wait_req();
        n = 0;
        while (wt_req_o !== 1'b1 && n < 40000) begin
            @(posedge clk_i);
            n++;
        end
    endtask : wait_req

    // cycles between two buzzer edges
    task automatic tone_half();
        logic v;
        // a tone switch may glitch the first edge; time the third
        for (int e = 0; e < 3; e++) begin
            v = buzzer_o;
            n = 0;
            while (buzzer_o === v && n < 1000) begin
                @(posedge clk_i);
                n++;
            end
        end
    endtask : tone_half

    // enable from a cleared chain and time the first interval
    task automatic run_interval(input logic sel, input logic [1:0] spd,
                                input int exp);
        logic [7:0] c;
        c = {sel, 1'b1, 2'b00, spd, 2'b00};
        bus_write(A_CTRL, {24'h0, c}, 4'h1);
        bus_write(A_CTRL, {24'h0, c | 8'h02}, 4'h1);
        wait_req();
        near(n, exp, 8);
        bus_write(A_CTRL, {24'h0, c}, 4'h1);
    endtask : run_interval

    // main sequence
    initial begin
        rst_b_i = 1'b0;
        address_i = 12'h000;
        read_i = 1'b0;
        write_i = 1'b0;
        writedata_i = 32'h0000_0000;
        byteenable_i = 4'h0;
        subclk_i = 1'b0;
        sub_run = 1'b0;
        n_mismatch = 0;
        total_checks = 0;
        repeat (12) @(posedge clk_i);
        rst_b_i <= 1'b1;
        @(posedge clk_i);
        // reset values and holes in the map
        bus_read(A_CTRL, 32'h0000_0000);
        bus_read(A_STAT, 32'h0000_0000);
        bus_read(A_IREN, 32'h0000_0000);
        bus_read(A_CLR, 32'h0000_0000);
        bus_read(A_NONE, 32'h0000_0000);
        // fields read back; pending cannot be set by software
        bus_write(A_CTRL, 32'h0000_00fd, 4'h1);
        bus_read(A_CTRL, 32'h0000_00fc);
        bus_write(A_CTRL, 32'h0000_0000, 4'h0);
        bus_read(A_CTRL, 32'h0000_00fc);
        bus_write(A_CTRL, 32'h0000_0000, 4'h1);
        // clock select and interval lengths
        run_interval(1'b0, 2'b11, 16384);
        sub_run <= 1'b1;
        run_interval(1'b1, 2'b11, 256);
        run_interval(1'b1, 2'b10, 16384);
        run_interval(1'b1, 2'b01, 32768);
        // disable in mid-interval clears the chain
        bus_write(A_CTRL, 32'h0000_00ce, 4'h1);
        repeat (200) @(posedge clk_i);
        bus_write(A_CTRL, 32'h0000_00cc, 4'h1);
        bus_write(A_CTRL, 32'h0000_00ce, 4'h1);
        wait_req();
        near(n, 256, 8);
        // pending survives a write of one, cleared by zero
        bus_write(A_CTRL, 32'h0000_00cd, 4'h1);
        bus_read(A_CTRL, 32'h0000_00cd);
        check({31'h0, wt_req_o}, 32'h0000_0001);
        bus_write(A_CTRL, 32'h0000_00cc, 4'h1);
        bus_read(A_CTRL, 32'h0000_00cc);
        check({31'h0, wt_req_o}, 32'h0000_0000);
        // event with request disabled sets only the flag
        bus_write(A_CTRL, 32'h0000_008e, 4'h1);
        repeat (300) @(posedge clk_i);
        check({31'h0, wt_req_o}, 32'h0000_0000);
        bus_read(A_CTRL, 32'h0000_008f);
        bus_write(A_CTRL, 32'h0000_00cd, 4'h1);
        repeat (2) @(posedge clk_i);
        check({31'h0, wt_req_o}, 32'h0000_0001);
        bus_write(A_CTRL, 32'h0000_008c, 4'h1);
        // each buzzer tone as a half period in cycles
        for (int b = 0; b < 4; b++) begin
            bus_write(A_CTRL, {24'h0, 8'h82 | 8'(b << 4)}, 4'h1);
            tone_half();
            near(n, 64 >> b, 1);
        end
        bus_write(A_CTRL, 32'h0000_0080, 4'h1);
        repeat (3) @(posedge clk_i);
        check({31'h0, buzzer_o}, 32'h0000_0000);
        // sticky status, enable, masked clear and clear
        bus_read(A_STAT, 32'h0000_0001);
        check({31'h0, irq_o}, 32'h0000_0000);
        bus_write(A_IREN, 32'h0000_0001, 4'h1);
        repeat (2) @(posedge clk_i);
        check({31'h0, irq_o}, 32'h0000_0001);
        bus_read(A_IREN, 32'h0000_0001);
        bus_write(A_CLR, 32'h0000_0001, 4'h0);
        bus_write(A_STAT, 32'h0000_0000, 4'h1);
        bus_read(A_STAT, 32'h0000_0001);
        bus_write(A_CLR, 32'h0000_0001, 4'h1);
        repeat (2) @(posedge clk_i);
        check({31'h0, irq_o}, 32'h0000_0000);
        bus_read(A_STAT, 32'h0000_0000);
        final_report();
    end

    // hang guard; the tests take about 68000 cycles
    initial begin
        repeat (90000) @(posedge clk_i);
        n_mismatch++;
        final_report();
    end

endmodule : watch_interval_timer_tb
`default_nettype wire
